// >>> verilog/acg_config.sv
/*
 * acg_config: configuration registers of the converter front end: input
 * amplifier, reference multiplexer and buffers, clock source, modulator clock.
 * assumes: host on a four-wire serial port (mode 1), pins asynchronous.
 */
//
// Contract
// - amp enable 00 powers the amplifier down and bypasses it
// - gains 64 and 128 use analog 32 plus digital scaling
// - two-bit field selects internal or one of two external references
// - after reset the first external pair is the reference
// - power code 10 always on, 01 on but off in power-down
// - internal reference is off after reset
// - select code 10 connects the internal reference
// - reference buffer bits active low, 1 disables buffer
// - one clock-source bit picks internal oscillator or external clock
// - internal oscillator after power-up and after pin or command reset
// - modulator clock is the selected clock source (oscillator or external) divided by 16
// - amp code 01 enables; 10 and 11 reserved, never written
// - three-bit gain field selects gains 1 through 128
`timescale 1ns/100ps
module acg_config
   import acg_pkg::*;
(
   input wire logic CLK_SYS,          // 10 MHz system clock
   input wire logic RESET_N,          // sync reset pin, active low
   input wire logic CS_N,             // serial chip select, active low
   input wire logic SCLK,             // serial clock
   input wire logic DIN,              // serial data in
   output logic DOUT,                 // serial data out
   output logic DOUT_OE,              // data out enable, high while driving
   input wire logic POWER_DOWN,       // device power-down mode
   input wire logic OSC_TICK,         // internal oscillator tick
   input wire logic EXT_CLK,          // external clock pin
   output acg_cfg_type CFG,           // decoded front-end configuration
   output logic MOD_CLK_EN            // modulator clock enable pulse
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [1:0] cs_pipe;
   logic [2:0] sclk_pipe;
   logic [1:0] din_pipe;

   always_ff @(posedge CLK_SYS) begin
      cs_pipe <= {cs_pipe[0], CS_N};
      sclk_pipe <= {sclk_pipe[1:0], SCLK};
      din_pipe <= {din_pipe[0], DIN};
   end

   wire cs_active = ~cs_pipe[1];
   wire sclk_rise = sclk_pipe[1] & ~sclk_pipe[2];
   wire sclk_fall = ~sclk_pipe[1] & sclk_pipe[2];
   wire din_bit = din_pipe[1];

   ////////////////////////////////////////////////////////////////////////////
   // serial frame: command byte, then data byte; the reset command frame has no data byte
   logic [7:0] shift_in;
   logic [3:0] bit_count;
   logic second_byte;
   logic is_read;
   logic [4:0] addr;
   logic [7:0] shift_out;
   logic soft_reset;

   wire [7:0] next_shift_in = {shift_in[6:0], din_bit};
   wire byte_done = sclk_fall & cs_active & (bit_count == BITS_PER_BYTE - 4'h1);
   wire cmd_done = byte_done & ~second_byte;
   wire data_done = byte_done & second_byte;
   wire cmd_is_reset = (next_shift_in == CMD_RESET);
   wire write_strobe = data_done & ~is_read;

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] gain_setting;
   logic [7:0] data_rate_setting;
   logic [7:0] reference_control;

   // pin reset and the reset command both load the reset values of the three registers
   wire cfg_reset = ~RESET_N | soft_reset;
   wire wr_gain = write_strobe & (addr == ADDR_GAIN_SETTING);
   wire wr_rate = write_strobe & (addr == ADDR_DATA_RATE_SETTING);
   wire wr_ref = write_strobe & (addr == ADDR_REFERENCE_CONTROL);

   wire [4:0] next_addr = next_shift_in[4:0];
   wire [7:0] read_data =
      (next_addr == ADDR_GAIN_SETTING) ? gain_setting :
      (next_addr == ADDR_DATA_RATE_SETTING) ? data_rate_setting :
      (next_addr == ADDR_REFERENCE_CONTROL) ? reference_control : 8'h00;

   always_ff @(posedge CLK_SYS) begin
      if (cfg_reset) begin
         gain_setting <= RST_GAIN_SETTING;
         data_rate_setting <= RST_DATA_RATE_SETTING;
         reference_control <= RST_REFERENCE_CONTROL;
      end else begin
         if (wr_gain) begin
            gain_setting <= next_shift_in & MASK_GAIN_SETTING;
         end
         if (wr_rate) begin
            data_rate_setting <= next_shift_in & MASK_DATA_RATE_SETTING;
         end
         if (wr_ref) begin
            reference_control <= next_shift_in & MASK_REFERENCE_CONTROL;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame sequencer
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N || !cs_active) begin
         shift_in <= 8'h00;
         bit_count <= 4'h0;
         second_byte <= 1'b0;
         is_read <= 1'b0;
         addr <= 5'h00;
      end else if (sclk_fall) begin
         shift_in <= next_shift_in;
         bit_count <= byte_done ? 4'h0 : bit_count + 4'h1;
         if (cmd_done) begin
            second_byte <= ~cmd_is_reset;
            is_read <= next_shift_in[CMD_READ_BIT];
            addr <= next_addr;
         end else if (data_done) begin
            second_byte <= 1'b0;
         end
      end
   end

   // reset command takes effect once, at the end of its byte
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         soft_reset <= 1'b0;
      end else begin
         soft_reset <= cmd_done & cmd_is_reset;
      end
   end

   // read data shifts out msb first on rising edges of the data byte
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N || !cs_active) begin
         shift_out <= 8'h00;
         DOUT <= 1'b0;
      end else if (cmd_done) begin
         shift_out <= next_shift_in[CMD_READ_BIT] ? read_data : 8'h00;
      end else if (sclk_rise && second_byte) begin
         DOUT <= shift_out[7];
         shift_out <= {shift_out[6:0], 1'b0};
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         DOUT_OE <= 1'b0;
      end else begin
         DOUT_OE <= cs_active;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // decode of the stored fields
   wire [2:0] gain_code = gain_setting[GAIN_LSB +: 3];
   wire [1:0] amp_code = gain_setting[AMP_EN_LSB +: 2];
   wire [1:0] sel_code = reference_control[REF_SEL_LSB +: 2];
   wire [1:0] pwr_code = reference_control[REF_PWR_LSB +: 2];

   // reserved amp codes leave the amplifier on rather than bypassing the input
   wire amp_on = (amp_code != AMP_OFF_BYPASS);

   // the amplifier tops out at 32; higher gains finish in the digital path
   wire [2:0] analog_gain = (gain_code > GAIN_32) ? GAIN_32 : gain_code;
   wire [1:0] scale =
      (gain_code == GAIN_64) ? SCALE_X2 :
      (gain_code == GAIN_128) ? SCALE_X4 : SCALE_X1;

   // reserved select code falls back to the first external pair
   wire [1:0] ref_src =
      (sel_code == REF_INTERNAL) ? REF_INTERNAL :
      (sel_code == REF_PAIR1) ? REF_PAIR1 : REF_PAIR0;

   // code 11 is treated as off
   wire ref_on =
      (pwr_code == REF_PWR_ALWAYS) |
      ((pwr_code == REF_PWR_ON_PD_OFF) & ~POWER_DOWN);

   acg_cfg_type next_cfg;

   always_comb begin
      next_cfg.amp_power_on = amp_on;
      next_cfg.amp_bypass = ~amp_on;
      next_cfg.amp_analog_gain = analog_gain;
      next_cfg.digital_scale = scale;
      next_cfg.ref_source = ref_src;
      next_cfg.int_ref_on = ref_on;
      next_cfg.pos_buf_en = ~reference_control[POS_BUF_BIT];
      next_cfg.neg_buf_en = ~reference_control[NEG_BUF_BIT];
      next_cfg.clk_src_ext = data_rate_setting[CLK_SRC_BIT];
      next_cfg.data_rate = data_rate_setting[RATE_LSB +: 4];
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         CFG <= '0;
      end else begin
         CFG <= next_cfg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // modulator clock from the selected source
   logic mod_tick;

   acg_mod_clock #(
      .DIVIDE(MOD_DIVIDE)
   ) u_mod_clock (
      .clk(CLK_SYS),
      .rst_n(RESET_N),
      .use_ext(data_rate_setting[CLK_SRC_BIT]),
      .osc_tick(OSC_TICK),
      .ext_clk_pin(EXT_CLK),
      .mod_tick(mod_tick)
   );

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         MOD_CLK_EN <= 1'b0;
      end else begin
         MOD_CLK_EN <= mod_tick;
      end
   end

endmodule : acg_config

// >>> verilog/acg_pkg.sv
/*
 * acg_pkg: register map, field positions, reset values, codes and the
 * configuration carrier shared by the front-end configuration block.
 * assumes: 8-bit registers reached over the serial configuration port.
 */
package acg_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [4:0] ADDR_GAIN_SETTING = 5'h03;
   localparam logic [4:0] ADDR_DATA_RATE_SETTING = 5'h04;
   localparam logic [4:0] ADDR_REFERENCE_CONTROL = 5'h05;

   // reset values
   localparam logic [7:0] RST_GAIN_SETTING = 8'h08;
   localparam logic [7:0] RST_DATA_RATE_SETTING = 8'h00;
   localparam logic [7:0] RST_REFERENCE_CONTROL = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int GAIN_LSB = 0;
   localparam int AMP_EN_LSB = 3;
   localparam int RATE_LSB = 0;
   localparam int CLK_SRC_BIT = 6;
   localparam int REF_PWR_LSB = 0;
   localparam int REF_SEL_LSB = 2;
   localparam int NEG_BUF_BIT = 4;
   localparam int POS_BUF_BIT = 5;

   // writable bit masks, other bits read as zero
   localparam logic [7:0] MASK_GAIN_SETTING = 8'h1F;
   localparam logic [7:0] MASK_DATA_RATE_SETTING = 8'h4F;
   localparam logic [7:0] MASK_REFERENCE_CONTROL = 8'h3F;

   ////////////////////////////////////////////////////////////////////////////
   // codes
   localparam logic [1:0] AMP_OFF_BYPASS = 2'h0;
   localparam logic [1:0] AMP_ON = 2'h1;
   localparam logic [1:0] REF_PAIR0 = 2'h0;
   localparam logic [1:0] REF_PAIR1 = 2'h1;
   localparam logic [1:0] REF_INTERNAL = 2'h2;
   localparam logic [1:0] REF_PWR_OFF = 2'h0;
   localparam logic [1:0] REF_PWR_ON_PD_OFF = 2'h1;
   localparam logic [1:0] REF_PWR_ALWAYS = 2'h2;
   localparam logic [2:0] GAIN_32 = 3'h5;
   localparam logic [2:0] GAIN_64 = 3'h6;
   localparam logic [2:0] GAIN_128 = 3'h7;
   localparam logic [1:0] SCALE_X1 = 2'h0;
   localparam logic [1:0] SCALE_X2 = 2'h1;
   localparam logic [1:0] SCALE_X4 = 2'h2;

   // serial port: command byte bit 7 set means read, low five bits address
   localparam logic [7:0] CMD_RESET = 8'h06;
   localparam int CMD_READ_BIT = 7;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // modulator clock divide ratio
   localparam int MOD_DIVIDE = 16;

   ////////////////////////////////////////////////////////////////////////////
   // decoded configuration travelling to the analog front end
   typedef struct packed {
      logic amp_power_on;
      logic amp_bypass;
      logic [2:0] amp_analog_gain;
      logic [1:0] digital_scale;
      logic [1:0] ref_source;
      logic int_ref_on;
      logic pos_buf_en;
      logic neg_buf_en;
      logic clk_src_ext;
      logic [3:0] data_rate;
   } acg_cfg_type;

endpackage : acg_pkg

// >>> verilog/acg_mod_clock.sv
/*
 * acg_mod_clock: picks the system clock tick from the internal oscillator
 * or the external clock pin and divides it to the modulator enable.
 * assumes: osc_tick is a same-domain pulse; ext_clk_pin is asynchronous.
 */
`timescale 1ns/100ps
module acg_mod_clock
   import acg_pkg::*;
#(
   parameter int DIVIDE = MOD_DIVIDE
) (
   input wire logic clk,            // system clock
   input wire logic rst_n,          // sync reset, active low
   input wire logic use_ext,        // 1 selects the external clock pin
   input wire logic osc_tick,       // internal oscillator tick
   input wire logic ext_clk_pin,    // external clock pin
   output logic mod_tick            // one-cycle modulator clock enable
);

   localparam int CW = $clog2(DIVIDE);

   logic ext_meta;
   logic ext_sync;
   logic ext_last;
   logic [CW-1:0] div_count;

   wire ext_tick = ext_sync & ~ext_last;
   wire sel_tick = use_ext ? ext_tick : osc_tick;
   wire div_wrap = (div_count == CW'(DIVIDE - 1));

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      ext_meta <= ext_clk_pin;
      ext_sync <= ext_meta;
      ext_last <= ext_sync;
   end

   // one modulator tick per sixteen ticks of whichever source is selected
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         div_count <= '0;
         mod_tick <= 1'b0;
      end else begin
         mod_tick <= sel_tick & div_wrap;
         if (sel_tick) begin
            div_count <= div_wrap ? '0 : div_count + CW'(1);
         end
      end
   end

endmodule : acg_mod_clock

// >>> verification/acg_config_monitor.sv
/*
 * acg_config_monitor: concurrent checks on the decoded configuration and clock outputs.
 * assumes: bound to acg_config; OSC_TICK pulses are at least four cycles apart.
 */
`timescale 1ns/100ps
module acg_config_monitor
   import acg_pkg::*;
(
   input wire logic CLK_SYS,      // system clock
   input wire logic RESET_N,      // sync reset, active low
   input wire logic CS_N,         // serial chip select, active low
   input wire logic OSC_TICK,     // oscillator tick
   input wire logic DOUT,         // serial data out
   input wire logic DOUT_OE,      // data out enable
   input wire acg_cfg_type CFG,   // decoded configuration
   input wire logic MOD_CLK_EN    // modulator enable
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);

   ////////////////////////////////////////////////////////////////////////////
   // ticks since the last modulator pulse; only trusted while the external clock was never chosen
   logic [4:0] tick_cnt;
   logic clean;
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         tick_cnt <= 5'h00;
         clean <= 1'b1;
      end else begin
         if (CFG.clk_src_ext) clean <= 1'b0;
         if (MOD_CLK_EN) tick_cnt <= {4'h0, OSC_TICK};
         else if (OSC_TICK) tick_cnt <= tick_cnt + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence s_release;
      $rose(RESET_N);
   endsequence
   sequence s_defaults;
      CFG.amp_power_on && !CFG.amp_bypass && CFG.ref_source == REF_PAIR0 && !CFG.int_ref_on &&
      !CFG.clk_src_ext && CFG.pos_buf_en && CFG.neg_buf_en;
   endsequence
   property p_defaults;
      s_release |=> s_defaults;
   endproperty

   chk_reset_defaults: assert property (p_defaults) else $error("defaults wrong after reset");
   chk_bypass_powerdown: assert property (CFG.amp_bypass |-> !CFG.amp_power_on) else $error("bypass with amp on");
   chk_gain_cap: assert property (CFG.amp_analog_gain <= GAIN_32) else $error("analog gain above 32");
   chk_scale_split: assert property (CFG.digital_scale != SCALE_X1 |-> CFG.amp_analog_gain == GAIN_32 &&
      CFG.digital_scale != 2'h3) else $error("digital scale without gain 32");
   chk_ref_code: assert property (CFG.ref_source != 2'h3) else $error("reserved reference code");
   chk_div_sixteen: assert property (MOD_CLK_EN && clean |-> tick_cnt == 5'h10) else $error("divide not 16");
   chk_div_nomiss: assert property (clean |-> tick_cnt <= 5'h10) else $error("modulator pulse missed");
   chk_dout_quiet: assert property (!DOUT_OE |-> !DOUT) else $error("dout active while idle");
   // two synchroniser flops plus the output flop put the enable three edges behind the pin
   chk_oe_on_select: assert property ($fell(CS_N) |-> ##3 DOUT_OE) else $error("dout enable late after select");
   chk_oe_off_release: assert property ($rose(CS_N) |-> ##3 !DOUT_OE) else $error("dout enable stuck after release");
endmodule : acg_config_monitor

// >>> verification/acg_host_model.sv
/*
 * acg_host_model: host on the four-wire serial port, mode 1, msb first.
 * assumes: clk is the system clock; each SCLK phase lasts six system cycles.
 */
`timescale 1ns/100ps
module acg_host_model (
   input wire logic clk,      // system clock
   input wire logic dout,     // serial data from the device
   output logic cs_n,         // chip select, active low
   output logic sclk,         // serial clock, idles low
   output logic din           // serial data to the device
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din = 1'b0;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   // data changes on the rise, device takes it on the fall
   task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sclk = 1'b1;
         din = tx[i];
         step(6);
         rx[i] = dout;
         sclk = 1'b0;
         step(6);
      end
   endtask : shift

   // callers never pass reserved amp codes, and bypass only at gain 1
   // reference power, settling and buffer advice are the caller's concern
   task automatic frame(input logic [7:0] cmd, input logic [7:0] wd, input bit two, output logic [7:0] rd);
      logic [7:0] junk;
      step(1);
      cs_n = 1'b0;
      step(4);
      shift(cmd, junk);
      rd = 8'h00;
      if (two) shift(wd, rd);
      step(6);
      cs_n = 1'b1;
      din = ~din;
      step(8);
   endtask : frame
endmodule : acg_host_model

// >>> verification/tb_adc_reference_clock_gain_config.sv
/*
 * tb_adc_reference_clock_gain_config: directed bench for the front-end configuration block.
 * assumes: acg_host_model drives the serial port; oscillator and external clock made here.
 */
`timescale 1ns/100ps
module tb_adc_reference_clock_gain_config
   import acg_pkg::*;
;
   logic clk_sys = 1'b0, reset_n = 1'b0, power_down = 1'b0, osc_tick = 1'b0, ext_clk = 1'b0;
   logic cs_n, sclk, din, dout, dout_oe, mod_clk_en;
   acg_cfg_type cfg;
   logic [1:0] osc_ph = 2'h0, ext_ph = 2'h0;
   int n_errors = 0, check_count = 0;

   always #50 clk_sys = ~clk_sys;
   // oscillator tick every 4 cycles, external clock period 6 cycles, both free running
   always @(posedge clk_sys) begin
      #1;
      osc_ph = osc_ph + 2'h1;
      osc_tick = (osc_ph == 2'h0);
      ext_ph = (ext_ph == 2'h2) ? 2'h0 : ext_ph + 2'h1;
      if (ext_ph == 2'h0) ext_clk = ~ext_clk;
   end

   acg_config dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .CS_N(cs_n), .SCLK(sclk), .DIN(din), .DOUT(dout),
      .DOUT_OE(dout_oe), .POWER_DOWN(power_down), .OSC_TICK(osc_tick), .EXT_CLK(ext_clk), .CFG(cfg),
      .MOD_CLK_EN(mod_clk_en));
   acg_host_model host (.clk(clk_sys), .dout(dout), .cs_n(cs_n), .sclk(sclk), .din(din));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      logic [7:0] r;
      host.frame({3'h0, a}, v, 1'b1, r);
   endtask : wr

   task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] r;
      host.frame({3'h4, a}, 8'h00, 1'b1, r);
      check("readback", r, exp);
   endtask : rd_chk

   task automatic pulses(input int cycles, input int exp);
      int n = 0;
      repeat (cycles) begin
         @(posedge clk_sys);
         #1;
         if (mod_clk_en === 1'b1) n++;
      end
      check("mod pulses", n[7:0], exp[7:0]);
   endtask : pulses

   task automatic t_defaults();
      rd_chk(ADDR_GAIN_SETTING, 8'h08);
      rd_chk(ADDR_REFERENCE_CONTROL, 8'h00);
      rd_chk(ADDR_DATA_RATE_SETTING, 8'h00);
      check("buffers", {6'h00, cfg.pos_buf_en, cfg.neg_buf_en}, 8'h03);
      pulses(256, 4);
   endtask : t_defaults

   task automatic t_gain();
      for (int g = 0; g < 8; g++) begin
         wr(ADDR_GAIN_SETTING, 8'h08 | g[7:0]);
         check("gain", {5'h00, cfg.amp_analog_gain}, (g < 5) ? g[7:0] : 8'h05);
         check("scale", {6'h00, cfg.digital_scale}, (g > 5) ? g[7:0] - 8'h05 : 8'h00);
      end
      wr(ADDR_GAIN_SETTING, 8'h00);
      check("bypass", {6'h00, cfg.amp_power_on, cfg.amp_bypass}, 8'h01);
      wr(5'h1F, 8'h07);
      rd_chk(ADDR_GAIN_SETTING, 8'h00);
      rd_chk(5'h1F, 8'h00);
   endtask : t_gain

   task automatic t_reference();
      logic [7:0] v;
      for (int i = 0; i < 9; i++) begin
         v = {2'h0, i[1:0], 2'(i / 3), 2'(i % 3)};
         wr(ADDR_REFERENCE_CONTROL, v);
         check("ref sel", {6'h00, cfg.ref_source}, 8'(i / 3));
         check("bufs", {6'h00, cfg.pos_buf_en, cfg.neg_buf_en}, {6'h00, ~v[5:4]});
         for (int pd = 0; pd < 2; pd++) begin
            power_down = pd[0];
            host.step(3);
            check("ref on", {7'h00, cfg.int_ref_on}, 8'((i % 3 == 2) || (i % 3 == 1 && pd == 0)));
         end
      end
      wr(ADDR_REFERENCE_CONTROL, 8'hFF);
      rd_chk(ADDR_REFERENCE_CONTROL, 8'h3F);
      check("ref rsvd", {5'h00, cfg.ref_source, cfg.int_ref_on}, 8'h00);
   endtask : t_reference

   task automatic t_clock();
      logic [7:0] r;
      wr(ADDR_DATA_RATE_SETTING, 8'h45);
      rd_chk(ADDR_DATA_RATE_SETTING, 8'h45);
      check("clk src", {3'h0, cfg.clk_src_ext, cfg.data_rate}, 8'h15);
      pulses(192, 2);
      host.frame(CMD_RESET, 8'h00, 1'b0, r);
      check("clk src", {7'h00, cfg.clk_src_ext}, 8'h00);
      rd_chk(ADDR_DATA_RATE_SETTING, 8'h00);
      rd_chk(ADDR_GAIN_SETTING, 8'h08);
      pulses(256, 4);
   endtask : t_clock

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk_sys);
      #1 reset_n = 1'b1;
      host.step(5);
      t_defaults();
      t_gain();
      t_reference();
      t_clock();
      tally_and_finish();
   end

   initial begin
      repeat (60000) @(posedge clk_sys);
      n_errors++;
      tally_and_finish();
   end
endmodule : tb_adc_reference_clock_gain_config

bind acg_config acg_config_monitor u_mon (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .CS_N(CS_N), .OSC_TICK(OSC_TICK),
   .DOUT(DOUT), .DOUT_OE(DOUT_OE), .CFG(CFG), .MOD_CLK_EN(MOD_CLK_EN));
